// ---- hwcur_pkg.sv ----
// constants shared by the cursor array, its memory and the pixel mixer
// assumes one 40 MHz pixel clock and a host synchronous to it
//
// How it works
// - cursor image lives in 1024x8 array at indexes 0x0100..0x04ff
// - two bits per pixel, four pixels a byte, one 64x64 image
// - small size uses four 256-byte slots, slot field ignored at large size
// - large rows take 16 bytes from 0x0100, groups ascending by column
// - small size rows take 8 bytes from the chosen slot base
// - host accesses run on the pixel clock and may come any time
// - array read may spoil one displayed pixel, writes spoil none
// - index write landing in array range prefetches that byte
// - data read returns prefetch, then refetches, next address if auto
// - prefetch stops past 0x04ff or on a data write
// - advanced enable 0 gives standard decoding, 1 gives advanced
// - three 24-bit colours from 8-bit parts, independent of pixel format
// - advanced colour 0 is fixed black
// - transparent passes underlying pixel, highlight complements it
// - translucent halves each component, top bit from cursor colour
// - mode 01: codes give transparent, colour 1, colour 2, colour 3
// - mode 10: codes 00, 01, 10 give colour 1, colour 2, transparent
// - mode 11: 00 and 01 transparent, 10 colour 1, 11 colour 2
// - advanced codes 00..11 select colours 0..3
// - attribute register gives two bits per colour, colour 1 at 3:2
// - both give transparent, solid, highlight; translucent only advanced
// - cursor mode 00 hides the cursor, anything else enables it
// - size select chooses 32x32 or 64x64 image
package hwcur_pkg;

	// array geometry
	localparam int          MEM_DEPTH   = 1024;
	localparam int          MEM_ADDR_W  = 10;
	localparam int          MEM_DATA_W  = 8;
	localparam logic [15:0] ARRAY_FIRST = 16'h0100;
	localparam logic [15:0] ARRAY_LAST  = 16'h04ff;
	localparam logic [15:0] IDX_STEP    = 16'h0001;
	localparam logic [15:0] IDX_RESET   = 16'h0000;

	// host register select codes
	localparam logic [1:0] SEL_IDX_LOW  = 2'h0;
	localparam logic [1:0] SEL_IDX_HIGH = 2'h1;
	localparam logic [1:0] SEL_IDX_DATA = 2'h2;

	// cursor mode field
	localparam logic [1:0] MODE_OFF  = 2'h0;
	localparam logic [1:0] MODE_STD0 = 2'h1;
	localparam logic [1:0] MODE_STD1 = 2'h2;
	localparam logic [1:0] MODE_STD2 = 2'h3;

	// size and order controls
	localparam logic SIZE_32        = 1'b0;
	localparam logic SIZE_64        = 1'b1;
	localparam logic ORDER_R_TO_L   = 1'b0;
	localparam logic ORDER_L_TO_R   = 1'b1;

	// advanced attributes, also used as the internal display kind
	localparam logic [1:0] ATTR_TRANSPARENT = 2'h0;
	localparam logic [1:0] ATTR_SOLID       = 2'h1;
	localparam logic [1:0] ATTR_TRANSLUCENT = 2'h2;
	localparam logic [1:0] ATTR_HIGHLIGHT   = 2'h3;

	localparam logic [23:0] BLACK     = 24'h000000;
	localparam logic [23:0] PIX_RESET = 24'h000000;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;

	// prefetch sequencer states
	typedef enum logic [2:0] {
		pf_idle  = 3'b001,
		pf_fetch = 3'b010,
		pf_load  = 3'b100
	} hwcur_pf_e;

endpackage

// ---- hwcur_mem_if.sv ----
// signals between the cursor control logic and its array memory
// assumes write and read ports both run on the pixel clock
`timescale 1ns/1ps
interface hwcur_mem_if;
	import hwcur_pkg::*;

	logic                  wr_en;
	logic [MEM_ADDR_W-1:0] wr_addr;
	logic [MEM_DATA_W-1:0] wr_data;
	logic [MEM_ADDR_W-1:0] rd_addr;
	logic [MEM_DATA_W-1:0] rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data,
	              output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data,
	              input rd_addr, output rd_data);
endinterface

// ---- hwcur_mem.sv ----
// cursor image storage: one write port, one registered read port
// assumes addresses are already offset to zero by the caller
`timescale 1ns/1ps
module hwcur_mem (
	// clock
	input wire logic clk,
	// access port
	hwcur_mem_if.mem port
);
	import hwcur_pkg::*;

	logic [MEM_DATA_W-1:0] store [MEM_DEPTH];

	// separate write port keeps host writes off the display read path
	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			store[port.wr_addr] <= port.wr_data;
		end
	end

	// read data always from a register, one cycle after the address
	always_ff @(posedge clk) begin
		port.rd_data <= store[port.rd_addr];
	end
endmodule

// ---- hwcur_top.sv ----
// cursor array with indexed host access, prefetch and the pixel mixer
// assumes host strobes and display inputs are synchronous to clk
// assumes position and clipping logic supplies row, column and hit
`timescale 1ns/1ps
module hwcur_top (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     srst,
	// host indexed access
	input  wire logic [1:0]               host_sel,
	input  wire logic                     host_wr,
	input  wire logic                     host_rd,
	input  wire logic [7:0]               host_wdata,
	input  wire logic                     auto_inc,
	output logic      [7:0]               host_rdata,
	output logic      [15:0]              index_value,
	// cursor controls
	input  wire logic [1:0]               cursor_mode,
	input  wire logic                     pointer_size_select,
	input  wire logic [1:0]               small_image_slot_select,
	input  wire logic                     in_byte_pixel_order,
	input  wire logic                     advanced_attr_enable,
	input  wire logic [7:0]               advanced_cursor_attributes,
	input  wire logic [3:1][7:0]          colour_red,
	input  wire logic [3:1][7:0]          colour_green,
	input  wire logic [3:1][7:0]          colour_blue,
	// display pixel stream
	input  wire logic                     cursor_hit,
	input  wire logic [5:0]               cursor_row,
	input  wire logic [5:0]               cursor_col,
	input  wire logic [23:0]              under_pixel,
	output logic      [23:0]              mixed_pixel
);
	import hwcur_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// index decode, used by every host access path
	function automatic logic in_array(input logic [15:0] idx);
		in_array = (idx >= ARRAY_FIRST) && (idx <= ARRAY_LAST);
	endfunction

	// pick one two-bit code out of a byte
	function automatic logic [1:0] pick_code(input logic [7:0] b,
	                                         input logic [1:0] p,
	                                         input logic order);
		logic [2:0] slot;
		slot = 3'h0;
		if (order == ORDER_R_TO_L) begin
			slot = {1'b0, p};
		end else begin
			slot = 3'h3 - {1'b0, p};
		end
		pick_code = b[{slot[1:0], 1'b0} +: 2];
	endfunction

	hwcur_mem_if mif ();

	hwcur_mem u_mem (
		.clk  (clk),
		.port (mif.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// host index and prefetch

	logic [15:0]     idx_reg, idx_next;
	logic [7:0]      pf_data_reg, pf_data_next;
	hwcur_pf_e       pf_reg, pf_next;
	logic            pf_start;
	logic            pf_stop;
	logic [15:0]     idx_off;
	logic [15:0]     wr_off;

	assign idx_off = idx_reg - ARRAY_FIRST;
	assign wr_off  = idx_reg - ARRAY_FIRST;

	// all host strobes are taken on clk, so no crossing is needed
	always_comb begin
		idx_next    = idx_reg;
		pf_start    = 1'b0;
		pf_stop     = 1'b0;
		mif.wr_en   = 1'b0;
		mif.wr_addr = wr_off[MEM_ADDR_W-1:0];
		mif.wr_data = host_wdata;
		if (host_wr) begin
			if (host_sel == SEL_IDX_LOW) begin
				idx_next = {idx_reg[15:8], host_wdata};
				pf_start = in_array({idx_reg[15:8], host_wdata});
			end else if (host_sel == SEL_IDX_HIGH) begin
				idx_next = {host_wdata, idx_reg[7:0]};
				pf_start = in_array({host_wdata, idx_reg[7:0]});
			end else if (host_sel == SEL_IDX_DATA) begin
				mif.wr_en = in_array(idx_reg);
				pf_stop   = 1'b1;
				if (auto_inc) begin
					idx_next = idx_reg + IDX_STEP;
				end
			end
		end else if (host_rd && (host_sel == SEL_IDX_DATA)) begin
			if (auto_inc) begin
				idx_next = idx_reg + IDX_STEP;
				pf_start = in_array(idx_reg + IDX_STEP);
			end else begin
				pf_start = in_array(idx_reg);
			end
		end
	end

	// prefetch steals the read port for one cycle only
	always_comb begin
		pf_next      = pf_reg;
		pf_data_next = pf_data_reg;
		case (pf_reg)
			pf_idle: begin
				if (pf_start) begin
					pf_next = pf_fetch;
				end
			end
			pf_fetch: begin
				pf_next = pf_load;
			end
			pf_load: begin
				pf_data_next = mif.rd_data;
				pf_next      = pf_idle;
			end
			default: begin
				pf_next = pf_idle;
			end
		endcase
		// a fresh trigger restarts, a data write abandons the fetch
		if (pf_start) begin
			pf_next = pf_fetch;
		end else if (pf_stop) begin
			pf_next = pf_idle;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			idx_reg     <= IDX_RESET;
			pf_reg      <= pf_idle;
			pf_data_reg <= BYTE_ZERO;
		end else begin
			idx_reg     <= idx_next;
			pf_reg      <= pf_next;
			pf_data_reg <= pf_data_next;
		end
	end

	assign host_rdata  = pf_data_reg;
	assign index_value = idx_reg;

	////////////////////////////////////////////////////////////////////////
	// display read address

	logic [MEM_ADDR_W-1:0] disp_addr;

	always_comb begin
		if (pointer_size_select == SIZE_64) begin
			disp_addr = {cursor_row, cursor_col[5:2]};
		end else begin
			disp_addr = {small_image_slot_select,
			             cursor_row[4:0], cursor_col[4:2]};
		end
	end

	// a prefetch displaces exactly one display fetch, so one pixel at most
	assign mif.rd_addr = (pf_reg == pf_fetch) ?
	                     idx_off[MEM_ADDR_W-1:0] : disp_addr;

	////////////////////////////////////////////////////////////////////////
	// stage 1: align display inputs with the array read data

	logic        s1_hit_reg, s1_hit_next;
	logic [1:0]  s1_pix_reg, s1_pix_next;
	logic [23:0] s1_under_reg, s1_under_next;

	always_comb begin
		s1_hit_next   = cursor_hit && (cursor_mode != MODE_OFF);
		s1_pix_next   = cursor_col[1:0];
		s1_under_next = under_pixel;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s1_hit_reg   <= 1'b0;
			s1_pix_reg   <= 2'h0;
			s1_under_reg <= PIX_RESET;
		end else begin
			s1_hit_reg   <= s1_hit_next;
			s1_pix_reg   <= s1_pix_next;
			s1_under_reg <= s1_under_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stage 2: decode the cursor pixel and mix

	logic [1:0]  code;
	logic [1:0]  kind;
	logic [1:0]  col_sel;
	logic [23:0] colour;
	logic [23:0] dimmed;
	logic [23:0] mixed_next;

	assign code = pick_code(mif.rd_data, s1_pix_reg, in_byte_pixel_order);

	// decode the code into a display kind and a colour number
	always_comb begin
		kind    = ATTR_TRANSPARENT;
		col_sel = 2'h0;
		if (advanced_attr_enable) begin
			col_sel = code;
			kind    = advanced_cursor_attributes[{code, 1'b0} +: 2];
		end else begin
			case (cursor_mode)
				MODE_STD0: begin
					col_sel = code;
					kind    = (code == 2'h0) ? ATTR_TRANSPARENT : ATTR_SOLID;
				end
				MODE_STD1: begin
					col_sel = code + 2'h1;
					if (code == 2'h2) begin
						kind = ATTR_TRANSPARENT;
					end else if (code == 2'h3) begin
						kind = ATTR_HIGHLIGHT;
					end else begin
						kind = ATTR_SOLID;
					end
				end
				MODE_STD2: begin
					col_sel = code - 2'h1;
					kind    = code[1] ? ATTR_SOLID : ATTR_TRANSPARENT;
				end
				default: begin
					kind = ATTR_TRANSPARENT;
				end
			endcase
		end
	end

	// colour registers feed straight through, no format conversion
	always_comb begin
		if (col_sel == 2'h0) begin
			colour = BLACK;
		end else begin
			colour = {colour_red[col_sel], colour_green[col_sel],
			          colour_blue[col_sel]};
		end
	end

	// halve each component and borrow the colour's top bit
	genvar gc;
	generate
		for (gc = 0; gc < 3; gc++) begin : g_dim
			assign dimmed[gc*8 +: 8] = {colour[gc*8 + 7],
			                            s1_under_reg[gc*8 + 1 +: 7]};
		end
	endgenerate

	// translucent only ever appears through the advanced attribute path
	always_comb begin
		mixed_next = s1_under_reg;
		if (s1_hit_reg) begin
			case (kind)
				ATTR_TRANSPARENT: mixed_next = s1_under_reg;
				ATTR_SOLID:       mixed_next = colour;
				ATTR_TRANSLUCENT: mixed_next = dimmed;
				ATTR_HIGHLIGHT:   mixed_next = ~s1_under_reg;
				default:          mixed_next = s1_under_reg;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mixed_pixel <= PIX_RESET;
		end else begin
			mixed_pixel <= mixed_next;
		end
	end

endmodule

// ---- hwcur_assertions.sv ----
// port checker for the cursor block, bound onto hwcur_top
// assumes one pixel clock and a synchronous active-high reset
`timescale 1ns/1ps
module hwcur_assertions import hwcur_pkg::*; (
	// clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// host access
	input wire logic [1:0]  host_sel,
	input wire logic        host_wr,
	input wire logic        host_rd,
	input wire logic [7:0]  host_wdata,
	input wire logic        auto_inc,
	input wire logic [7:0]  host_rdata,
	input wire logic [15:0] index_value,
	// pixel path
	input wire logic [1:0]  cursor_mode,
	input wire logic        advanced_attr_enable,
	input wire logic [7:0]  advanced_cursor_attributes,
	input wire logic        cursor_hit,
	input wire logic [23:0] under_pixel,
	input wire logic [23:0] mixed_pixel
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////
	// strobes as the block decodes them, write wins over read
	logic idx_wr, dat_wr, dat_rd, trig;
	assign idx_wr = host_wr && host_sel[1] == 1'b0;
	assign dat_wr = host_wr && host_sel == SEL_IDX_DATA;
	assign dat_rd = host_rd && !host_wr && host_sel == SEL_IDX_DATA;
	assign trig   = idx_wr || dat_rd;
	// high then low index load, one idle cycle between
	sequence s_set_index;
		host_wr && host_sel == SEL_IDX_HIGH ##2
		host_wr && host_sel == SEL_IDX_LOW;
	endsequence
	// a pixel condition held over two cycles, pixel unchanged
	sequence s_held(c);
		c ##1 c && $stable(under_pixel);
	endsequence
	a_index_pair: assert property (
		s_set_index |=> index_value ==
		{$past(host_wdata, 3), $past(host_wdata)})
		else $error("index load wrong");
	a_data_step: assert property (
		dat_wr && auto_inc |=> index_value == $past(index_value) + IDX_STEP)
		else $error("index not stepped on write");
	a_read_step: assert property (
		dat_rd && auto_inc |=> index_value == $past(index_value) + IDX_STEP)
		else $error("index not stepped on read");
	a_index_still: assert property (
		(dat_wr || dat_rd) && !auto_inc |=> $stable(index_value))
		else $error("index moved without auto increment");
	a_fetch_only: assert property (
		$changed(host_rdata) |-> $past(trig, 3))
		else $error("read data changed without prefetch");
	a_mode_off: assert property (
		s_held(cursor_mode == MODE_OFF) |=>
		mixed_pixel == $past(under_pixel))
		else $error("pixel altered with cursor off");
	a_miss_pass: assert property (
		s_held(!cursor_hit) |=> mixed_pixel == $past(under_pixel))
		else $error("pixel altered outside cursor");
	a_adv_high: assert property (
		s_held(cursor_hit && cursor_mode != MODE_OFF &&
		advanced_attr_enable && advanced_cursor_attributes == 8'hff)
		|=> mixed_pixel == ~$past(under_pixel))
		else $error("highlight not complemented");
endmodule
bind hwcur_top hwcur_assertions chk_u (.clk, .srst, .host_sel, .host_wr,
	.host_rd, .host_wdata, .auto_inc, .host_rdata, .index_value,
	.cursor_mode, .advanced_attr_enable, .advanced_cursor_attributes,
	.cursor_hit, .under_pixel, .mixed_pixel);

// ---- hwcur_host.sv ----
// host processor model driving the indexed access strobes
// assumes its tasks are called from one process only
`timescale 1ns/1ps
module hwcur_host (
	// clock
	input wire logic  clk,
	// indexed access
	output logic [1:0] host_sel,
	output logic       host_wr,
	output logic       host_rd,
	output logic [7:0] host_wdata,
	output logic       auto_inc
);
	import hwcur_pkg::*;
	// idle bus at time zero
	initial begin
		host_sel = 2'h3;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = 8'h00;
		auto_inc = 1'b0;
	end
	// one write pulse, everything held to the sampling edge
	task put(input logic [1:0] s, input logic [7:0] d, input logic a);
		@(posedge clk);
		#1;
		host_sel = s;
		host_wdata = d;
		auto_inc = a;
		host_wr = 1'b1;
		@(posedge clk);
		#1;
		host_wr = 1'b0;
		host_sel = 2'h3;
		host_wdata = ~d; // released lines carry no stale data
	endtask
	// index high then low: a range hit starts a prefetch
	task set_index(input logic [15:0] i);
		put(SEL_IDX_HIGH, i[15:8], 1'b0);
		put(SEL_IDX_LOW, i[7:0], 1'b0);
	endtask
	// reads wait out the three-cycle prefetch first
	task get(input logic a);
		repeat (3) @(posedge clk);
		#1;
		host_sel = SEL_IDX_DATA;
		auto_inc = a;
		host_rd = 1'b1;
		@(posedge clk);
		#1;
		host_rd = 1'b0;
		host_sel = 2'h3;
	endtask
endmodule

// ---- hwcur_top_bench.sv ----
// self-checking bench: array fill, readback, prefetch stop, mixer
// assumes the host model and the bound port checker
`timescale 1ns/1ps
module hwcur_top_bench;
	import hwcur_pkg::*;
	logic clk, srst, host_wr, host_rd, auto_inc, mark;
	logic size, order, adv, hit;
	logic [1:0] host_sel, mode, slot, m;
	logic [7:0] host_wdata, host_rdata, attr;
	logic [15:0] index_value;
	logic [3:1][7:0] cr, cg, cb;
	logic [5:0] row, col;
	logic [23:0] under, mixed;
	logic [31:0] lf;
	logic [7:0] mem_m [MEM_DEPTH];
	logic [7:0] exp_rd [$];
	logic [23:0] exp_px [$];
	int n_fail, checks;
	hwcur_host host (.clk, .host_sel, .host_wr, .host_rd, .host_wdata,
		.auto_inc);
	hwcur_top DUT (.clk, .srst, .host_sel, .host_wr, .host_rd,
		.host_wdata, .auto_inc, .host_rdata, .index_value,
		.cursor_mode(mode), .pointer_size_select(size),
		.small_image_slot_select(slot), .in_byte_pixel_order(order),
		.advanced_attr_enable(adv), .advanced_cursor_attributes(attr),
		.colour_red(cr), .colour_green(cg), .colour_blue(cb),
		.cursor_hit(hit), .cursor_row(row), .cursor_col(col),
		.under_pixel(under), .mixed_pixel(mixed));
	////////////////////////////////////////
	// linear feedback shift register source
	function logic [31:0] rnd();
		lf = {lf[30:0], ^(lf & 32'h80200003)};
		return lf;
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		checks++;
		if (seen !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task roll();
		{mode, slot, size, order, adv, hit, row, col, attr} = 28'(rnd());
		{cr, cg} = 48'({rnd(), rnd()});
		{cb, under} = 48'({rnd(), rnd()});
	endtask
	// reference mixer worked out from the array copy
	function automatic logic [23:0] px_exp();
		logic [7:0] b;
		logic [1:0] k, n, code;
		logic [23:0] c;
		b = size ? mem_m[{row, col[5:2]}]
			: mem_m[{slot, row[4:0], col[4:2]}];
		code = 2'(order ? b >> (3'd6 - {col[1:0], 1'b0})
			: b >> {col[1:0], 1'b0});
		n = code;
		k = code == 2'h0 ? ATTR_TRANSPARENT : ATTR_SOLID;
		if (adv)
			k = 2'(attr >> {code, 1'b0});
		else if (mode == MODE_STD1) begin
			n = code + 2'h1;
			k = code == 2'h2 ? ATTR_TRANSPARENT
				: (code == 2'h3 ? ATTR_HIGHLIGHT : ATTR_SOLID);
		end else if (mode == MODE_STD2) begin
			n = code - 2'h1;
			k = code[1] ? ATTR_SOLID : ATTR_TRANSPARENT;
		end
		c = n == 2'h0 ? BLACK : {cr[n], cg[n], cb[n]};
		if (!hit || mode == MODE_OFF || k == ATTR_TRANSPARENT)
			return under;
		if (k == ATTR_HIGHLIGHT)
			return ~under;
		if (k == ATTR_SOLID)
			return c;
		return {c[23], under[23:17], c[15], under[15:9],
			c[7], under[7:1]};
	endfunction
	task end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// watcher: reads in their strobe cycle, pixels two edges on
	always @(negedge clk) begin
		if (host_rd && !host_wr && host_sel == SEL_IDX_DATA)
			chk("rdata", host_rdata, exp_rd.pop_front());
		if (m[1])
			chk("pixel", mixed, exp_px.pop_front());
		m = {m[0], mark};
	end
	// a hang ends the run as a failure
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
	initial begin
		lf = 32'h63cd;
		srst = 1'b1;
		mark = 1'b0;
		m = 2'h0;
		roll();
		repeat (3) @(posedge clk);
		#1;
		srst = 1'b0;
		// fill the whole array, then read it back with auto increment
		host.set_index(ARRAY_FIRST);
		for (int i = 0; i < MEM_DEPTH; i++) begin
			mem_m[i] = 8'(rnd());
			host.put(SEL_IDX_DATA, mem_m[i], 1'b1);
		end
		chk("index", index_value, ARRAY_LAST + IDX_STEP);
		host.set_index(ARRAY_FIRST);
		for (int i = 0; i <= MEM_DEPTH; i++) begin
			exp_rd.push_back(mem_m[i < MEM_DEPTH ? i : MEM_DEPTH - 1]);
			host.get(1'b1);
		end
		// a data write stops prefetch; the next read restarts it
		host.set_index(16'h0200);
		repeat (3) @(posedge clk);
		exp_rd.push_back(mem_m[10'h100]);
		host.put(SEL_IDX_DATA, ~mem_m[10'h100], 1'b1);
		mem_m[10'h100] = ~mem_m[10'h100];
		host.get(1'b1);
		exp_rd.push_back(mem_m[10'h102]);
		host.get(1'b1);
		// no auto increment: index holds, same byte is fetched again
		exp_rd.push_back(mem_m[10'h103]);
		host.get(1'b0);
		host.put(SEL_IDX_DATA, ~mem_m[10'h103], 1'b0);
		exp_rd.push_back(mem_m[10'h103]);
		mem_m[10'h103] = ~mem_m[10'h103];
		host.get(1'b0);
		exp_rd.push_back(mem_m[10'h103]);
		host.get(1'b0);
		chk("index", index_value, 32'h0203);
		// random pixels, each held three cycles, every fourth with all attributes at highlight
		for (int i = 0; i < 400; i++) begin
			@(posedge clk);
			#1;
			roll();
			if (i % 4 == 0)
				attr = 8'hff;
			exp_px.push_back(px_exp());
			mark = 1'b1;
			@(posedge clk);
			#1;
			mark = 1'b0;
			@(posedge clk);
		end
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule
